// ===== rtl/state_regfile.sv
// Register file holding the managed architectural registers, with registered read data.
`timescale 1ns/100ps
`default_nettype none
module state_regfile (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic we_in,
  input wire logic [3:0] waddr_in,
  input wire logic [63:0] wdata_in,
  input wire logic [3:0] raddr_in,
  output logic [63:0] rdata_out
);
  logic [63:0] mem_ff [16];

  // Every register clears on reset so that pending and rights mirrors agree with it.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 16; i++) begin
        mem_ff[i] <= 64'h0;
      end
    end else if (we_in) begin
      mem_ff[waddr_in] <= wdata_in;
    end
  end

  // Read data shows the stored word one cycle after the address.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= 64'h0;
    end else begin
      rdata_out <= mem_ff[raddr_in];
    end
  end
endmodule
`default_nettype wire

// ===== rtl/xstate_engine.sv
// Save and restore engine for state components 9 to 14 with checks and side effects.
`timescale 1ns/100ps
`default_nettype none
module xstate_engine (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic os_save_feature_enable_in,
  input wire logic [15:0] user_component_mask_in,
  input wire logic [15:0] supervisor_component_mask_in,
  input wire xstate_pkg::op_req_t op_in,
  output logic op_ready_out,
  input wire logic vm_exit_in,
  output var xstate_pkg::mem_req_t mem_out,
  input wire logic [63:0] mem_rdata_in,
  input wire xstate_pkg::msr_req_t msr_in,
  output logic msr_ready_out,
  output logic msr_rvalid_out,
  output logic [63:0] msr_rdata_out,
  output logic [31:0] access_rights_out,
  output logic user_irq_flag_out,
  output logic user_irq_pending_out,
  output logic busy_out,
  output logic done_out,
  output logic fault_out,
  output logic abort_out
);
  xstate_pkg::state_t st_ff, nxt_st;
  logic [3:0] slot_ff, nxt_slot;
  logic restore_ff, loaded14_ff, fault_pend_ff, vmx_pend_ff, flag_ff, rr_nz_ff, msr_rv_ff;
  logic rights_pend_ff, done_ff, fault_ff, abort_ff;
  logic [31:0] rights_ff, rights_new_ff;
  logic [63:0] misc_hold_ff, rf_rdata, rf_wdata;
  logic [3:0] rf_raddr, rf_waddr, first_slot, after_slot;
  logic rf_we, msr_wr, load_wr, clr_wr, load_bad, vec_busy;
  xstate_pkg::mem_req_t mem_ff;

  function automatic logic [4:0] slot_comp(input logic [3:0] s);
    if (s == xstate_pkg::SLOT_RIGHTS) return xstate_pkg::COMP_RIGHTS;
    else if (s == xstate_pkg::SLOT_ASID) return xstate_pkg::COMP_ASID;
    else if (s <= xstate_pkg::SLOT_PL3) return xstate_pkg::COMP_UFG;
    else if (s <= xstate_pkg::SLOT_PL2) return xstate_pkg::COMP_SFG;
    else if (s == xstate_pkg::SLOT_DUTY) return xstate_pkg::COMP_DUTY;
    else return xstate_pkg::COMP_UIRQ;
  endfunction

  // A component moves only with the feature enable and its own mask bit.
  function automatic logic slot_en(input logic [3:0] s, input logic os, input logic [15:0] ucm,
                                   input logic [15:0] scm);
    logic [4:0] c;
    c = slot_comp(s);
    if (c == xstate_pkg::COMP_RIGHTS) return os & ucm[9];
    else return os & scm[c[3:0]];
  endfunction

  // Lowest enabled slot at or above the given one, or none.
  function automatic logic [3:0] next_en(input logic [3:0] from, input logic os, input logic [15:0] ucm,
                                         input logic [15:0] scm);
    logic [3:0] r;
    r = xstate_pkg::SLOT_NONE;
    for (int i = xstate_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
      if (4'(i) >= from && slot_en(4'(i), os, ucm, scm)) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // Save-area byte address of each slot.
  function automatic logic [11:0] slot_addr(input logic [3:0] s);
    case (s)
      xstate_pkg::SLOT_RIGHTS: slot_addr = xstate_pkg::BASE_RIGHTS + xstate_pkg::OFF_RIGHTS;
      xstate_pkg::SLOT_ASID: slot_addr = xstate_pkg::BASE_ASID + xstate_pkg::OFF_ASID;
      xstate_pkg::SLOT_UCET: slot_addr = xstate_pkg::BASE_UFG + xstate_pkg::OFF_UCET;
      xstate_pkg::SLOT_PL3: slot_addr = xstate_pkg::BASE_UFG + xstate_pkg::OFF_PL3;
      xstate_pkg::SLOT_PL0: slot_addr = xstate_pkg::BASE_SFG;
      xstate_pkg::SLOT_PL1: slot_addr = xstate_pkg::BASE_SFG + xstate_pkg::OFF_PL_STRIDE;
      xstate_pkg::SLOT_PL2: slot_addr = 12'(xstate_pkg::BASE_SFG + 2 * xstate_pkg::OFF_PL_STRIDE);
      xstate_pkg::SLOT_DUTY: slot_addr = xstate_pkg::BASE_DUTY + xstate_pkg::OFF_DUTY;
      xstate_pkg::SLOT_HANDLER: slot_addr = xstate_pkg::BASE_UIRQ + xstate_pkg::OFF_HANDLER;
      xstate_pkg::SLOT_STACK: slot_addr = xstate_pkg::BASE_UIRQ + xstate_pkg::OFF_STACK;
      xstate_pkg::SLOT_MISC: slot_addr = xstate_pkg::BASE_UIRQ + xstate_pkg::OFF_MISC;
      xstate_pkg::SLOT_PD: slot_addr = xstate_pkg::BASE_UIRQ + xstate_pkg::OFF_PD;
      xstate_pkg::SLOT_RR: slot_addr = xstate_pkg::BASE_UIRQ + xstate_pkg::OFF_RR;
      default: slot_addr = xstate_pkg::BASE_UIRQ + xstate_pkg::OFF_TT;
    endcase
  endfunction

  function automatic logic is_canon(input logic [63:0] v);
    return (&v[63:xstate_pkg::MAX_LA_W - 1]) | ~(|v[63:xstate_pkg::MAX_LA_W - 1]);
  endfunction

  function automatic logic [63:0] canon(input logic [63:0] v);
    return {{(64 - xstate_pkg::MAX_LA_W){v[xstate_pkg::MAX_LA_W - 1]}}, v[xstate_pkg::MAX_LA_W - 1:0]};
  endfunction

  // Memory image of a slot; reserved fields are forced to zero.
  function automatic logic [63:0] save_fmt(input logic [3:0] s, input logic [63:0] v, input logic flag);
    logic [63:0] r;
    r = v;
    case (s)
      xstate_pkg::SLOT_RIGHTS: r = {32'h0, v[xstate_pkg::RIGHTS_W - 1:0]};
      xstate_pkg::SLOT_HANDLER, xstate_pkg::SLOT_STACK: r = canon(v);
      xstate_pkg::SLOT_PD: r = canon(v) & ~64'h3F;
      xstate_pkg::SLOT_TT: r = canon(v) & ~64'hE;
      xstate_pkg::SLOT_MISC: r = {flag, 23'h0, v[xstate_pkg::VEC_HI:0]};
      default: r = v;
    endcase
    return r;
  endfunction

  // True when a value read for restore must be refused.
  function automatic logic bad_val(input logic [3:0] s, input logic [63:0] v);
    case (s)
      xstate_pkg::SLOT_HANDLER, xstate_pkg::SLOT_STACK: bad_val = ~is_canon(v);
      xstate_pkg::SLOT_MISC: bad_val = |v[xstate_pkg::MISC_RSV_HI:xstate_pkg::MISC_RSV_LO];
      xstate_pkg::SLOT_PD: bad_val = ~is_canon(v) | (|v[xstate_pkg::PD_RSV_HI:0]);
      xstate_pkg::SLOT_TT: bad_val = ~is_canon(v) | (|v[xstate_pkg::TT_RSV_HI:xstate_pkg::TT_RSV_LO]);
      default: bad_val = 1'b0;
    endcase
  endfunction

  function automatic xstate_pkg::state_t goto_st(input logic [3:0] s, input logic rs);
    if (s == xstate_pkg::SLOT_NONE) return xstate_pkg::ST_FIN;
    else if (!rs) return xstate_pkg::ST_RD_REG;
    else if (s == xstate_pkg::SLOT_HANDLER) return xstate_pkg::ST_VEC_RD;
    else return xstate_pkg::ST_RD_MEM;
  endfunction

  // Slot walk, handshakes and register-file port selection.
  assign first_slot = next_en(4'h0, os_save_feature_enable_in, user_component_mask_in,
                              supervisor_component_mask_in);
  assign after_slot = next_en(4'(slot_ff + 4'h1), os_save_feature_enable_in, user_component_mask_in,
                              supervisor_component_mask_in);
  assign op_ready_out = (st_ff == xstate_pkg::ST_IDLE);
  assign msr_ready_out = op_ready_out & ~op_in.valid;
  assign busy_out = ~op_ready_out;
  assign vec_busy = |rf_rdata[xstate_pkg::VEC_HI:xstate_pkg::VEC_LO];
  assign load_bad = bad_val(slot_ff, mem_rdata_in);
  assign msr_wr = msr_ready_out & msr_in.valid & msr_in.we;
  assign load_wr = (st_ff == xstate_pkg::ST_CHK) & ~load_bad & ~vm_exit_in;
  assign clr_wr = (st_ff == xstate_pkg::ST_CLR_WR);
  assign rf_we = msr_wr | load_wr | clr_wr;
  assign rf_waddr = clr_wr ? xstate_pkg::SLOT_MISC : (load_wr ? slot_ff : msr_in.idx);
  assign rf_raddr = op_ready_out ? msr_in.idx : ((st_ff == xstate_pkg::ST_VEC_RD) ? xstate_pkg::SLOT_MISC : slot_ff);

  // Writes: notify-vector clear, restore load with the flag bit stripped, or direct access.
  assign rf_wdata = clr_wr ? {misc_hold_ff[63:xstate_pkg::VEC_HI + 1], 8'h00, misc_hold_ff[31:0]}
                  : load_wr ? ((slot_ff == xstate_pkg::SLOT_MISC) ? {1'b0, mem_rdata_in[62:0]}
                  : (slot_ff == xstate_pkg::SLOT_RIGHTS) ? {32'h0, mem_rdata_in[31:0]} : mem_rdata_in)
                  : msr_in.wdata;

  state_regfile u_regs (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .we_in(rf_we),
    .waddr_in(rf_waddr),
    .wdata_in(rf_wdata),
    .raddr_in(rf_raddr),
    .rdata_out(rf_rdata)
  );

  // Sequencer; a fault anywhere ends the walk so later components stay untouched.
  always_comb begin
    nxt_st = st_ff;
    nxt_slot = slot_ff;
    case (st_ff)
      xstate_pkg::ST_IDLE: begin
        if (op_in.valid) begin
          nxt_slot = first_slot;
          nxt_st = goto_st(first_slot, op_in.restore);
        end
      end
      xstate_pkg::ST_VEC_RD: nxt_st = xstate_pkg::ST_VEC_CHK;
      xstate_pkg::ST_VEC_CHK: nxt_st = vec_busy ? xstate_pkg::ST_FIN : xstate_pkg::ST_RD_MEM;
      xstate_pkg::ST_RD_REG: nxt_st = xstate_pkg::ST_WR_MEM;
      xstate_pkg::ST_WR_MEM: begin
        nxt_slot = after_slot;
        nxt_st = (slot_ff == xstate_pkg::SLOT_TT) ? xstate_pkg::ST_CLR_WR : goto_st(after_slot, 1'b0);
      end
      xstate_pkg::ST_RD_MEM: nxt_st = xstate_pkg::ST_MEM_WAIT;
      xstate_pkg::ST_MEM_WAIT: nxt_st = xstate_pkg::ST_CHK;
      xstate_pkg::ST_CHK: begin
        if (load_bad || vm_exit_in) begin
          nxt_st = loaded14_ff ? xstate_pkg::ST_CLR_WR : xstate_pkg::ST_FIN;
        end else begin
          nxt_slot = after_slot;
          nxt_st = goto_st(after_slot, 1'b1);
        end
      end
      xstate_pkg::ST_CLR_WR: nxt_st = xstate_pkg::ST_FIN;
      xstate_pkg::ST_FIN: nxt_st = xstate_pkg::ST_IDLE;
      default: nxt_st = xstate_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_ff <= xstate_pkg::ST_IDLE;
      slot_ff <= xstate_pkg::SLOT_NONE;
    end else begin
      st_ff <= nxt_st;
      slot_ff <= nxt_slot;
    end
  end

  // Per-operation flags; they clear when a new operation is taken, and restore_ff loads its type.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || (op_ready_out && op_in.valid)) begin
      restore_ff <= op_in.valid & op_in.restore & rst_n_in;
      loaded14_ff <= 1'b0;
      fault_pend_ff <= 1'b0;
      vmx_pend_ff <= 1'b0;
    end else begin
      loaded14_ff <= loaded14_ff | (load_wr & (slot_ff >= xstate_pkg::SLOT_HANDLER));
      fault_pend_ff <= fault_pend_ff | ((st_ff == xstate_pkg::ST_VEC_CHK) & vec_busy)
                       | ((st_ff == xstate_pkg::ST_CHK) & load_bad);
      vmx_pend_ff <= vmx_pend_ff | ((st_ff == xstate_pkg::ST_CHK) & vm_exit_in & ~load_bad);
    end
  end

  // Misc image used for the vector clear, and the flag that rides in its top bit.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      misc_hold_ff <= 64'h0;
      flag_ff <= 1'b0;
    end else begin
      if (st_ff == xstate_pkg::ST_VEC_CHK || (st_ff == xstate_pkg::ST_WR_MEM && slot_ff == xstate_pkg::SLOT_MISC)) begin
        misc_hold_ff <= rf_rdata;
      end else if (load_wr && slot_ff == xstate_pkg::SLOT_MISC) begin
        misc_hold_ff <= rf_wdata;
      end
      if (load_wr && slot_ff == xstate_pkg::SLOT_MISC) begin
        flag_ff <= mem_rdata_in[xstate_pkg::FLAG_BIT];
      end
    end
  end

  // Save-area requests come from a flop; a save writes, a restore reads.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mem_ff <= '0;
    end else begin
      mem_ff.req <= (st_ff == xstate_pkg::ST_WR_MEM) | (st_ff == xstate_pkg::ST_RD_MEM);
      mem_ff.we <= (st_ff == xstate_pkg::ST_WR_MEM);
      mem_ff.addr <= slot_addr(slot_ff);
      mem_ff.be <= (slot_ff == xstate_pkg::SLOT_RIGHTS) ? xstate_pkg::BE_RIGHTS : xstate_pkg::BE_FULL;
      mem_ff.wdata <= save_fmt(slot_ff, rf_rdata, flag_ff);
    end
  end

  // Rights value changes only outside a restore or in its ST_FIN state, so checks never see a half-loaded value.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rights_ff <= 32'h0;
      rights_new_ff <= 32'h0;
      rights_pend_ff <= 1'b0;
    end else begin
      if (msr_wr && msr_in.idx == xstate_pkg::SLOT_RIGHTS) begin
        rights_ff <= msr_in.wdata[31:0];
      end else if (st_ff == xstate_pkg::ST_FIN && rights_pend_ff) begin
        rights_ff <= rights_new_ff;
      end
      if (load_wr && slot_ff == xstate_pkg::SLOT_RIGHTS) begin
        rights_new_ff <= mem_rdata_in[31:0];
      end
      rights_pend_ff <= (rights_pend_ff & (st_ff != xstate_pkg::ST_FIN)) | (load_wr & (slot_ff == xstate_pkg::SLOT_RIGHTS));
    end
  end

  // Status pulses and the pending mirror of the request word.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rr_nz_ff <= 1'b0;
      msr_rv_ff <= 1'b0;
      done_ff <= 1'b0;
      fault_ff <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      if (rf_we && rf_waddr == xstate_pkg::SLOT_RR) begin
        rr_nz_ff <= |rf_wdata;
      end
      msr_rv_ff <= msr_ready_out & msr_in.valid & ~msr_in.we;
      done_ff <= (st_ff == xstate_pkg::ST_FIN);
      fault_ff <= (st_ff == xstate_pkg::ST_FIN) & fault_pend_ff;
      abort_ff <= (st_ff == xstate_pkg::ST_FIN) & vmx_pend_ff;
    end
  end

  assign mem_out = mem_ff;
  assign msr_rvalid_out = msr_rv_ff;
  assign msr_rdata_out = rf_rdata;
  assign access_rights_out = rights_ff;
  assign user_irq_flag_out = flag_ff;
  assign user_irq_pending_out = rr_nz_ff;
  assign done_out = done_ff;
  assign fault_out = fault_ff;
  assign abort_out = abort_ff;

  // Checks on the walk, the memory image and the side effects.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  rights_hold_a: assert property (restore_ff && busy_out && st_ff != xstate_pkg::ST_FIN |=> $stable(access_rights_out))
    else $error("rights value changed during restore");
  rights_lane_a: assert property (mem_out.req && mem_out.we && mem_out.addr == xstate_pkg::BASE_RIGHTS |->
    mem_out.be == xstate_pkg::BE_RIGHTS && mem_out.wdata[63:32] == 32'h0)
    else $error("rights word uses wrong lanes");
  gate_walk_a: assert property (st_ff == xstate_pkg::ST_RD_REG || st_ff == xstate_pkg::ST_RD_MEM |->
    slot_en(slot_ff, os_save_feature_enable_in, user_component_mask_in, supervisor_component_mask_in))
    else $error("disabled component accessed");
  vec_gate_a: assert property (st_ff == xstate_pkg::ST_VEC_CHK && vec_busy |-> !rf_we ##1 !rf_we ##1 fault_out)
    else $error("nonzero vector did not fault cleanly");
  misc_rsv_a: assert property (mem_out.req && mem_out.we && mem_out.addr == slot_addr(xstate_pkg::SLOT_MISC) |->
    mem_out.wdata[62:40] == 23'h0 && mem_out.wdata[63] == flag_ff)
    else $error("misc image reserved bits not zero");
  canon_save_a: assert property (mem_out.req && mem_out.we && mem_out.addr == slot_addr(xstate_pkg::SLOT_TT) |->
    is_canon(mem_out.wdata) && mem_out.wdata[3:1] == 3'h0)
    else $error("target table saved non-canonical");
  save_clear_a: assert property (!restore_ff && st_ff == xstate_pkg::ST_WR_MEM && slot_ff == xstate_pkg::SLOT_TT |=>
    rf_we && rf_waddr == xstate_pkg::SLOT_MISC && rf_wdata[39:32] == 8'h00 && rf_wdata[31:0] == misc_hold_ff[31:0])
    else $error("vector not cleared after save");
  bad_block_a: assert property (st_ff == xstate_pkg::ST_CHK && load_bad |-> !rf_we ##1 !(rf_we && rf_waddr != xstate_pkg::SLOT_MISC))
    else $error("bad value loaded");
  partial_fix_a: assert property (st_ff == xstate_pkg::ST_CHK && (load_bad || vm_exit_in) && loaded14_ff |=>
    clr_wr ##2 done_out)
    else $error("partial load not repaired");
  pend_irq_a: assert property (rf_we && rf_waddr == xstate_pkg::SLOT_RR |=> user_irq_pending_out == (|$past(rf_wdata)))
    else $error("pending does not follow request word");
  save_done_c: cover property (!restore_ff && st_ff == xstate_pkg::ST_CLR_WR ##2 done_out);
  restore_fault_c: cover property (restore_ff ##0 st_ff == xstate_pkg::ST_VEC_CHK && vec_busy);
  restore_pend_c: cover property (restore_ff && done_out && !fault_out && user_irq_pending_out);
endmodule
`default_nettype wire

// ===== shared/xstate_pkg.sv
// Shared constants and types for the extended-state save and restore engine.
package xstate_pkg;
  // Architectural register slots held in the register file.
  localparam logic [3:0] SLOT_RIGHTS = 4'h0;
  localparam logic [3:0] SLOT_ASID = 4'h1;
  localparam logic [3:0] SLOT_UCET = 4'h2;
  localparam logic [3:0] SLOT_PL3 = 4'h3;
  localparam logic [3:0] SLOT_PL0 = 4'h4;
  localparam logic [3:0] SLOT_PL1 = 4'h5;
  localparam logic [3:0] SLOT_PL2 = 4'h6;
  localparam logic [3:0] SLOT_DUTY = 4'h7;
  localparam logic [3:0] SLOT_HANDLER = 4'h8;
  localparam logic [3:0] SLOT_STACK = 4'h9;
  localparam logic [3:0] SLOT_MISC = 4'hA;
  localparam logic [3:0] SLOT_PD = 4'hB;
  localparam logic [3:0] SLOT_RR = 4'hC;
  localparam logic [3:0] SLOT_TT = 4'hD;
  localparam logic [3:0] SLOT_NONE = 4'hF;
  localparam int unsigned NUM_SLOTS = 14;

  // State component numbers.
  localparam logic [4:0] COMP_RIGHTS = 5'h09;
  localparam logic [4:0] COMP_ASID = 5'h0A;
  localparam logic [4:0] COMP_UFG = 5'h0B;
  localparam logic [4:0] COMP_SFG = 5'h0C;
  localparam logic [4:0] COMP_DUTY = 5'h0D;
  localparam logic [4:0] COMP_UIRQ = 5'h0E;

  // Section base byte addresses in the save area.
  localparam logic [11:0] BASE_RIGHTS = 12'h000;
  localparam logic [11:0] BASE_ASID = 12'h008;
  localparam logic [11:0] BASE_UFG = 12'h010;
  localparam logic [11:0] BASE_SFG = 12'h020;
  localparam logic [11:0] BASE_DUTY = 12'h038;
  localparam logic [11:0] BASE_UIRQ = 12'h040;

  // Byte offsets inside each section.
  localparam logic [11:0] OFF_RIGHTS = 12'h000;
  localparam logic [11:0] OFF_ASID = 12'h000;
  localparam logic [11:0] OFF_UCET = 12'h000;
  localparam logic [11:0] OFF_PL3 = 12'h008;
  localparam logic [11:0] OFF_PL_STRIDE = 12'h008;
  localparam logic [11:0] OFF_DUTY = 12'h000;
  localparam logic [11:0] OFF_HANDLER = 12'h000;
  localparam logic [11:0] OFF_STACK = 12'h008;
  localparam logic [11:0] OFF_MISC = 12'h010;
  localparam logic [11:0] OFF_PD = 12'h018;
  localparam logic [11:0] OFF_RR = 12'h020;
  localparam logic [11:0] OFF_TT = 12'h028;

  // Field positions and lane enables.
  localparam int unsigned RIGHTS_W = 32;
  localparam int unsigned FLAG_BIT = 63;
  localparam int unsigned VEC_HI = 39;
  localparam int unsigned VEC_LO = 32;
  localparam int unsigned MISC_RSV_HI = 62;
  localparam int unsigned MISC_RSV_LO = 40;
  localparam int unsigned PD_RSV_HI = 5;
  localparam int unsigned TT_RSV_HI = 3;
  localparam int unsigned TT_RSV_LO = 1;
  localparam int unsigned MAX_LA_W = 48;
  localparam logic [7:0] BE_RIGHTS = 8'h0F;
  localparam logic [7:0] BE_FULL = 8'hFF;

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_VEC_RD = 10'h002,
    ST_VEC_CHK = 10'h004,
    ST_RD_REG = 10'h008,
    ST_WR_MEM = 10'h010,
    ST_RD_MEM = 10'h020,
    ST_MEM_WAIT = 10'h040,
    ST_CHK = 10'h080,
    ST_CLR_WR = 10'h100,
    ST_FIN = 10'h200
  } state_t;

  typedef struct packed {
    logic valid;
    logic restore;
  } op_req_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [11:0] addr;
    logic [7:0] be;
    logic [63:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic [3:0] idx;
    logic [63:0] wdata;
  } msr_req_t;
endpackage

// ===== tb/save_area_model.sv
// Behavioural save area that answers the engine's memory requests.
`timescale 1ns/100ps
`default_nettype none
module save_area_model (
  input wire logic clk_in,
  input wire xstate_pkg::mem_req_t mem_in,
  output logic [63:0] rdata_out
);
  logic [63:0] m [16];
  // Starts all ones so that a write outside its byte lanes shows up.
  initial begin
    foreach (m[i]) m[i] = '1;
    rdata_out = '0;
  end
  // Reads answer one cycle later; between reads the bus alternates between the inverse of the last word read and that word.
  always @(posedge clk_in) begin
    rdata_out <= (mem_in.req && !mem_in.we) ? m[mem_in.addr[6:3]] : ~rdata_out;
    for (int b = 0; b < 8; b++) begin
      if (mem_in.req && mem_in.we && mem_in.be[b]) m[mem_in.addr[6:3]][8*b +: 8] <= mem_in.wdata[8*b +: 8];
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the extended-state save and restore engine.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, v) begin n_compared++; if ((v) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", n, e, v); end end
module tb_top;
  logic clk = 0, rst_n = 0, en = 1, vmx = 0, flg, pend, done, flt, abt, rv;
  logic [15:0] um = 16'h0200, sm = 16'h7C00;
  xstate_pkg::op_req_t op = '0;
  xstate_pkg::msr_req_t msr = '0;
  xstate_pkg::mem_req_t mem;
  logic [63:0] rdata, mrd, v;
  logic [31:0] rights;
  logic [2:0] res;
  int fails = 0, n_compared = 0, cyc = 0;
  xstate_engine xstate_engine_inst (.clk_in(clk), .rst_n_in(rst_n), .os_save_feature_enable_in(en),
    .user_component_mask_in(um), .supervisor_component_mask_in(sm), .op_in(op), .op_ready_out(),
    .vm_exit_in(vmx), .mem_out(mem), .mem_rdata_in(rdata), .msr_in(msr), .msr_ready_out(), .msr_rvalid_out(rv),
    .msr_rdata_out(mrd), .access_rights_out(rights), .user_irq_flag_out(flg), .user_irq_pending_out(pend),
    .busy_out(), .done_out(done), .fault_out(flt), .abort_out(abt));
  save_area_model save_area_model_inst (.clk_in(clk), .mem_in(mem), .rdata_out(rdata));
  always #2 clk = ~clk;
  // A hung handshake ends the run here; the ceiling is far above the longest sequence.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      complete_run();
    end
  end
  // Word as written through the register port, or as it must land in the save area.
  function automatic logic [63:0] word(input int s, input bit saved);
    if (s == 8) return saved ? 64'hFFFF_8000_0000_0000 : 64'h0000_8000_0000_0000;
    if (s == 10) return 64'h0000_0012_0000_0A00;
    return 64'(s) * 64'h100;
  endfunction
  // Bus tasks start on an edge and end on one, so no signal is driven twice in a step.
  task automatic wr(input int i, input logic [63:0] d);
    msr <= '{1'b1, 1'b1, 4'(i), d};
    @(posedge clk);
    msr.valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input int i);
    msr <= '{1'b1, 1'b0, 4'(i), 64'h0};
    @(posedge clk);
    msr.valid <= 1'b0;
    #1 v = mrd;
    `CHK("read valid", 1'b1, rv)
    @(posedge clk);
  endtask
  task automatic run(input logic r);
    op <= '{1'b1, r};
    @(posedge clk);
    op.valid <= 1'b0;
    res = 3'h0;
    repeat (300) begin
      #1 res = {done, flt, abt};
      if (res != 3'h0) break;
      @(posedge clk);
    end
    @(posedge clk);
  endtask
  task automatic t_save();
    for (int s = 0; s < 14; s++) wr(s, word(s, 0));
    run(0);
    `CHK("save end", 3'h4, res)
    `CHK("rights word", 64'hFFFF_FFFF_0000_0000, save_area_model_inst.m[0])
    for (int s = 1; s < 14; s++) `CHK("save word", word(s, 1), save_area_model_inst.m[s])
    rd(10);
    `CHK("vector cleared", 64'h0000_0000_0000_0A00, v)
  endtask
  task automatic t_vec();
    wr(10, 64'h0000_0001_0000_0000);
    save_area_model_inst.m[12] = 64'h5;
    run(1);
    `CHK("vector fault", 3'h6, res)
    rd(12);
    `CHK("request kept", 64'h0000_0000_0000_0C00, v)
  endtask
  task automatic t_rest();
    wr(10, 64'h0);
    save_area_model_inst.m[0] = 64'h0000_0000_1234_5678;
    save_area_model_inst.m[10] = 64'h8000_0000_0000_0A00;
    save_area_model_inst.m[12] = 64'h0;
    run(1);
    `CHK("restore end", 3'h4, res)
    `CHK("rights", 32'h1234_5678, rights)
    `CHK("flag", 1'b1, flg)
    `CHK("pending", 1'b0, pend)
  endtask
  // Each bad word must be refused; in the last entry the exit is held high, so the restore stops at slot 0 before its clean word is read.
  task automatic t_bad();
    int w [5] = '{8, 10, 11, 13, 1};
    logic [63:0] b [5] = '{64'h0001_0000_0000_0000, 64'h0000_0100_0000_0000, 64'h1, 64'h2, 64'h100};
    logic [63:0] k;
    for (int i = 0; i < 5; i++) begin
      k = save_area_model_inst.m[w[i]];
      save_area_model_inst.m[w[i]] = b[i];
      vmx <= (i == 4);
      run(1);
      `CHK("refusal", (i == 4) ? 3'h5 : 3'h6, res)
      save_area_model_inst.m[w[i]] = k;
    end
    vmx <= 1'b0;
  endtask
  task automatic t_off();
    en <= 1'b0;
    wr(1, 64'h77);
    run(0);
    `CHK("disabled save", 64'h0000_0000_0000_0100, save_area_model_inst.m[1])
    rd(1);
    `CHK("direct access", 64'h0000_0000_0000_0077, v)
  endtask
  task automatic complete_run();
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Reset for two cycles, then the scenarios in turn.
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_save();
    t_vec();
    t_rest();
    t_bad();
    t_off();
    complete_run();
  end
endmodule
`default_nettype wire
